//--- design/btc_defines.svh
`ifndef BTC_DEFINES_SVH
`define BTC_DEFINES_SVH

// ==========================================================
// Register offsets
`define BTC_OFF_CTRL       8'h00
`define BTC_OFF_STATUS     8'h04
`define BTC_OFF_STATES     8'h08
`define BTC_OFF_LINES      8'h0C
`define BTC_OFF_OCCLEFT    8'h10
`define BTC_OFF_ARMTIME_LO 8'h14
`define BTC_OFF_ARMTIME_HI 8'h18
`define BTC_OFF_ARMFLAGS   8'h1C
`define BTC_OFF_INTSTAT    8'h20
`define BTC_OFF_INTMASK    8'h24
`define BTC_OFF_RDPTR      8'h28
`define BTC_OFF_RDDATA     8'h2C
`define BTC_OFF_TERM_BASE  2'h1
`define BTC_TERM_PATTERN   2'h0
`define BTC_TERM_MASK      2'h1
`define BTC_TERM_COUNT     2'h2

// ==========================================================
// Field positions
`define BTC_CTRL_START     0
`define BTC_CTRL_HALT      1
`define BTC_CTRL_ARMEN     2
`define BTC_CTRL_CNTEN     3
`define BTC_CTRL_LAST_LSB  4
`define BTC_INT_TRIG       0
`define BTC_INT_DONE       1
`define BTC_INT_HALT       2
`define BTC_INT_ARM        3
`define BTC_INT_W          4

// ==========================================================
// Sizes and reset values
`define BTC_SAMPLE_W       32
`define BTC_NTERMS         4
`define BTC_OCC_W          16
`define BTC_OCC_RST        16'h0001
`define BTC_LAST_RST       2'h0
`define BTC_MEM_DEPTH      1024
`define BTC_SMALL_DEPTH    512
`define BTC_ARM_W          40

// ==========================================================
// Timing
`define BTC_CLK_PERIOD_NS  8
`define BTC_ARM_MIN_NS     40
`define BTC_ARM_MAX_US     41943
`define BTC_ARM_LG_S       1374
`define BTC_ARM_MIN_CYC    ((`BTC_ARM_MIN_NS + `BTC_CLK_PERIOD_NS - 1) / `BTC_CLK_PERIOD_NS)
`define BTC_ARM_MAX_CYC    ((64'd1000 * `BTC_ARM_MAX_US) / `BTC_CLK_PERIOD_NS)
`define BTC_ARM_LG_CYC     ((64'd1000000000 * `BTC_ARM_LG_S) / `BTC_CLK_PERIOD_NS)

`endif

//--- design/btc_pkg.sv
`include "btc_defines.svh"

package btc_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WAIT  = 3'b001,
      ST_STORE = 3'b010,
      ST_DONE  = 3'b011,
      ST_HALT  = 3'b100
   } btc_state_t;

   typedef enum logic [1:0] {
      RUN_IDLE     = 2'b00,
      RUN_RUNNING  = 2'b01,
      RUN_COMPLETE = 2'b10,
      RUN_HALTED   = 2'b11
   } btc_run_t;

   typedef enum logic [1:0] {
      ARM_IGNORED  = 2'b00,
      ARM_NOT_RCVD = 2'b01,
      ARM_RCVD     = 2'b10
   } btc_arm_t;

   typedef struct packed {
      logic [`BTC_SAMPLE_W-1:0] pattern;
      logic [`BTC_SAMPLE_W-1:0] mask;
      logic [`BTC_OCC_W-1:0] count;
   } btc_term_cfg_t;

endpackage

//--- design/btc_term_match.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Masked compare of one sample against one sequencer term
module btc_term_match #(
   parameter int W = 32
) (
   input wire logic [W-1:0] sample,
   input wire logic [W-1:0] pattern,
   input wire logic [W-1:0] mask,
   output logic hit
);
   // A cleared mask bit is a don't-care, so an all-zero mask matches any state
   assign hit = ((sample ^ pattern) & mask) == '0;
endmodule

`default_nettype wire

//--- design/btc_trace_mem.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Trace store, one write port and one registered read port
module btc_trace_mem #(
   parameter int W = 32,
   parameter int DEPTH = 1024,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

`default_nettype wire

//--- design/btc_capture.sv
`timescale 1ns/10ps
`default_nettype none

`include "btc_defines.svh"

module btc_capture
   import btc_pkg::*;
#(
   parameter int MEM_DEPTH = `BTC_MEM_DEPTH,
   parameter bit LARGE_VARIANT = 1'b0,
   parameter longint ARM_MAX_CYC = `BTC_ARM_MAX_CYC,
   parameter longint ARM_LG_CYC = `BTC_ARM_LG_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [31:0] rdData,
   input wire logic [`BTC_SAMPLE_W-1:0] probeBus,
   input wire logic armIn,
   output logic trigOut,
   output logic irq
);
   localparam int AW = $clog2(MEM_DEPTH);
   localparam int CW = AW + 1;
   localparam int SW = `BTC_SAMPLE_W;
   localparam int OW = `BTC_OCC_W;
   localparam int TW = 3;
   // A shallow build must never promise more lines than it has
   localparam int SMALL_LIM = (MEM_DEPTH < `BTC_SMALL_DEPTH) ? MEM_DEPTH : `BTC_SMALL_DEPTH;

   // ==========================================================
   // Input synchronisers
   logic [SW-1:0] probeS1_r;
   logic [SW-1:0] probeS2_r;
   logic armS1_r;
   logic armS2_r;
   logic armS3_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         probeS1_r <= '0;
         probeS2_r <= '0;
      end else begin
         probeS1_r <= probeBus;
         probeS2_r <= probeS1_r;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armS1_r <= 1'b0;
         armS2_r <= 1'b0;
         armS3_r <= 1'b0;
      end else begin
         armS1_r <= armIn;
         armS2_r <= armS1_r;
         armS3_r <= armS2_r;
      end
   end

   logic armEvt;
   assign armEvt = armS2_r & ~armS3_r;

   // ==========================================================
   // Control and term configuration
   logic armEn_r;
   logic cntEn_r;
   logic [1:0] lastTerm_r;
   logic [`BTC_INT_W-1:0] intMask_r;
   btc_term_cfg_t cfg_r [`BTC_NTERMS];
   logic ctrlWr;
   logic startCmd;
   logic haltCmd;
   logic termWr;

   assign ctrlWr = wrEn && (addr == `BTC_OFF_CTRL);
   assign startCmd = ctrlWr && wrData[`BTC_CTRL_START];
   assign haltCmd = ctrlWr && wrData[`BTC_CTRL_HALT] && !wrData[`BTC_CTRL_START];
   assign termWr = wrEn && (addr[7:6] == `BTC_OFF_TERM_BASE);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armEn_r <= 1'b0;
         cntEn_r <= 1'b0;
         lastTerm_r <= `BTC_LAST_RST;
         intMask_r <= '0;
      end else begin
         if (ctrlWr) begin
            armEn_r <= wrData[`BTC_CTRL_ARMEN];
            cntEn_r <= wrData[`BTC_CTRL_CNTEN];
            lastTerm_r <= wrData[`BTC_CTRL_LAST_LSB +: 2];
         end
         if (wrEn && addr == `BTC_OFF_INTMASK) begin
            intMask_r <= wrData[`BTC_INT_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `BTC_NTERMS; i++) begin
            cfg_r[i] <= '{pattern: '0, mask: '0, count: `BTC_OCC_RST};
         end
      end else if (termWr) begin
         case (addr[3:2])
            `BTC_TERM_PATTERN: cfg_r[addr[5:4]].pattern <= wrData;
            `BTC_TERM_MASK: cfg_r[addr[5:4]].mask <= wrData;
            `BTC_TERM_COUNT: cfg_r[addr[5:4]].count <= wrData[OW-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Sequencer
   logic [`BTC_NTERMS-1:0] hit;
   btc_state_t state_r;
   logic [TW-1:0] curTerm_r;
   logic [TW-1:0] haltTerm_r;
   logic [OW-1:0] occLeft_r;
   logic [CW-1:0] wrPtr_r;
   logic [CW-1:0] depthLim;
   logic [1:0] nextIdx;
   logic termHit;
   logic branch;
   logic trig;
   logic memWe;
   logic storeLast;
   logic running;

   genvar g;
   for (g = 0; g < `BTC_NTERMS; g++) begin : gTerm
      btc_term_match #(.W(SW)) uMatch (
         .sample(probeS2_r),
         .pattern(cfg_r[g].pattern),
         .mask(cfg_r[g].mask),
         .hit(hit[g])
      );
   end

   assign depthLim = (!LARGE_VARIANT && cntEn_r) ? CW'(SMALL_LIM) : CW'(MEM_DEPTH);
   assign running = (state_r == ST_WAIT) || (state_r == ST_STORE);
   assign nextIdx = 2'(curTerm_r + 3'h1);
   assign termHit = (state_r == ST_WAIT) && hit[curTerm_r[1:0]];
   assign branch = termHit && (occLeft_r <= OW'(1));
   assign trig = branch && (curTerm_r == {1'b0, lastTerm_r}) && !haltCmd && !startCmd;
   assign memWe = trig || ((state_r == ST_STORE) && !haltCmd && !startCmd);
   assign storeLast = memWe && (wrPtr_r == depthLim - CW'(1));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         curTerm_r <= '0;
         haltTerm_r <= '0;
         occLeft_r <= '0;
      end else if (startCmd) begin
         state_r <= ST_WAIT;
         curTerm_r <= '0;
         occLeft_r <= cfg_r[0].count;
      end else if (haltCmd && running) begin
         state_r <= ST_HALT;
         haltTerm_r <= curTerm_r;
      end else begin
         case (state_r)
            ST_WAIT: begin
               if (termHit && !branch) begin
                  occLeft_r <= occLeft_r - OW'(1);
               end else if (branch) begin
                  curTerm_r <= curTerm_r + 3'h1;
                  occLeft_r <= trig ? '0 : cfg_r[nextIdx].count;
               end
               if (trig) begin
                  state_r <= storeLast ? ST_DONE : ST_STORE;
               end
            end
            ST_STORE: begin
               if (storeLast) begin
                  state_r <= ST_DONE;
               end
            end
            ST_IDLE, ST_DONE, ST_HALT: ;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
      end else if (startCmd) begin
         wrPtr_r <= '0;
      end else if (memWe) begin
         wrPtr_r <= wrPtr_r + CW'(1);
      end
   end

   logic trigInMem_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         trigInMem_r <= 1'b0;
      end else if (startCmd) begin
         trigInMem_r <= 1'b0;
      end else if (trig) begin
         trigInMem_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         trigOut <= 1'b0;
      end else if (trig) begin
         trigOut <= 1'b1;
      end else if (startCmd || haltCmd) begin
         trigOut <= 1'b0;
      end
   end

   // ==========================================================
   // Arm tracking
   logic armRcvd_r;
   logic armSeen_r;
   logic signed [`BTC_ARM_W-1:0] armTime_r;
   logic signed [`BTC_ARM_W-1:0] hiLim;
   logic signed [`BTC_ARM_W-1:0] loLim;
   logic armUnder;
   logic armOver;
   logic armUnknown;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armRcvd_r <= 1'b0;
      end else if (armEvt) begin
         armRcvd_r <= 1'b1;
      end else if (startCmd) begin
         armRcvd_r <= 1'b0;
      end
   end

   assign hiLim = LARGE_VARIANT ? `BTC_ARM_W'(ARM_LG_CYC) : `BTC_ARM_W'(ARM_MAX_CYC);
   assign loLim = LARGE_VARIANT ? -`BTC_ARM_W'(ARM_LG_CYC) : -`BTC_ARM_W'(`BTC_ARM_MIN_CYC);

   // Counts up from arm to trigger, down from trigger to a late arm; saturates one past a limit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armSeen_r <= 1'b0;
         armTime_r <= '0;
      end else if (startCmd) begin
         // An arm in the start cycle still counts, as for the status bit
         armSeen_r <= armEvt;
         armTime_r <= '0;
      end else begin
         if (armEvt) begin
            armSeen_r <= 1'b1;
         end
         if (armSeen_r && !trigInMem_r && state_r == ST_WAIT && armTime_r <= hiLim) begin
            armTime_r <= armTime_r + `BTC_ARM_W'(1);
         end else if (trigInMem_r && !armSeen_r && armTime_r >= loLim) begin
            armTime_r <= armTime_r - `BTC_ARM_W'(1);
         end
      end
   end

   assign armOver = armTime_r > hiLim;
   assign armUnder = armTime_r < loLim;
   assign armUnknown = !armEn_r || !trigInMem_r || !armSeen_r;

   // ==========================================================
   // Interrupts
   logic [`BTC_INT_W-1:0] intStat_r;
   logic [`BTC_INT_W-1:0] intSet;
   logic [`BTC_INT_W-1:0] intClr;

   assign intSet[`BTC_INT_TRIG] = trig;
   assign intSet[`BTC_INT_DONE] = storeLast && !startCmd;
   assign intSet[`BTC_INT_HALT] = haltCmd && running;
   assign intSet[`BTC_INT_ARM] = armEvt;
   assign intClr = (wrEn && addr == `BTC_OFF_INTSTAT) ? wrData[`BTC_INT_W-1:0] : '0;

   // Set beats a clear arriving in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         intStat_r <= '0;
      end else begin
         intStat_r <= (intStat_r & ~intClr) | intSet;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(intStat_r & intMask_r);
      end
   end

   // ==========================================================
   // Trace memory and read pointer
   logic [AW-1:0] rdPtr_r;
   logic [AW-1:0] rdAddr;
   logic [SW-1:0] memQ;
   logic dataRd;

   assign dataRd = rdEn && (addr == `BTC_OFF_RDDATA);

   // Look ahead so the memory output always shows the line the pointer names
   always_comb begin
      rdAddr = rdPtr_r;
      if (wrEn && addr == `BTC_OFF_RDPTR) begin
         rdAddr = wrData[AW-1:0];
      end else if (dataRd) begin
         rdAddr = rdPtr_r + AW'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdPtr_r <= '0;
      end else begin
         rdPtr_r <= rdAddr;
      end
   end

   btc_trace_mem #(.W(SW), .DEPTH(MEM_DEPTH)) uMem (
      .clk(mclk),
      .we(memWe),
      .waddr(wrPtr_r[AW-1:0]),
      .wdata(probeS2_r),
      .raddr(rdAddr),
      .rdata(memQ)
   );

   // ==========================================================
   // Register read
   btc_run_t runStat;
   btc_arm_t armStat;
   logic [TW-1:0] termRep;
   logic [CW-1:0] lastLine;
   logic [31:0] rdMux;

   always_comb begin
      case (state_r)
         ST_WAIT, ST_STORE: runStat = RUN_RUNNING;
         ST_DONE: runStat = RUN_COMPLETE;
         ST_HALT: runStat = RUN_HALTED;
         default: runStat = RUN_IDLE;
      endcase
   end

   assign armStat = !armEn_r ? ARM_IGNORED : (armRcvd_r ? ARM_RCVD : ARM_NOT_RCVD);
   assign termRep = (state_r == ST_HALT) ? haltTerm_r : curTerm_r;
   assign lastLine = (wrPtr_r == '0) ? '0 : wrPtr_r - CW'(1);

   always_comb begin
      rdMux = '0;
      case (addr)
         `BTC_OFF_CTRL: rdMux = {26'h0, lastTerm_r, cntEn_r, armEn_r, 2'h0};
         `BTC_OFF_STATUS: rdMux = {20'h0, 1'b0, termRep, 3'h0, trigInMem_r, armStat, runStat};
         `BTC_OFF_STATES: rdMux = {16'(depthLim), 16'(wrPtr_r)};
         `BTC_OFF_LINES: rdMux = {16'(lastLine), 16'h0000};
         `BTC_OFF_OCCLEFT: rdMux = 32'(occLeft_r);
         `BTC_OFF_ARMTIME_LO: rdMux = armTime_r[31:0];
         `BTC_OFF_ARMTIME_HI: rdMux = 32'(armTime_r[`BTC_ARM_W-1:32]);
         `BTC_OFF_ARMFLAGS: rdMux = {29'h0, armOver, armUnder, armUnknown};
         `BTC_OFF_INTSTAT: rdMux = 32'(intStat_r);
         `BTC_OFF_INTMASK: rdMux = 32'(intMask_r);
         `BTC_OFF_RDPTR: rdMux = 32'(rdPtr_r);
         `BTC_OFF_RDDATA: rdMux = memQ;
         default: begin
            if (addr[7:6] == `BTC_OFF_TERM_BASE) begin
               case (addr[3:2])
                  `BTC_TERM_PATTERN: rdMux = cfg_r[addr[5:4]].pattern;
                  `BTC_TERM_MASK: rdMux = cfg_r[addr[5:4]].mask;
                  `BTC_TERM_COUNT: rdMux = 32'(cfg_r[addr[5:4]].count);
                  default: rdMux = '0;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= '0;
      end else begin
         rdData <= rdEn ? rdMux : '0;
      end
   end
endmodule

`default_nettype wire

//--- dv/btc_bus_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Emulated processor bus: a counting bus gives every state a distinct value
module btc_bus_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic armReq,
   output logic [31:0] probeBus,
   output logic armIn
);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         probeBus <= 32'h0;
      end else begin
         probeBus <= probeBus + 32'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armIn <= 1'b0;
      end else begin
         armIn <= armReq;
      end
   end
endmodule
`default_nettype wire

//--- dv/btc_capture_props.sv
`timescale 1ns/10ps
`default_nettype none

module btc_capture_props #(
   parameter int MEM_DEPTH = 1024
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [31:0] rdData,
   input wire logic [31:0] probeBus,
   input wire logic armIn,
   input wire logic trigOut,
   input wire logic irq
);
   logic ctrlWr;
   logic ctrlCmd;
   logic runSeen_r;
   logic maskNz_r;

   assign ctrlWr = wrEn && (addr == 8'h00);
   assign ctrlCmd = ctrlWr && (wrData[1:0] != 2'b00);

   // Start arms the trigger output, a halt takes the chance away
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         runSeen_r <= 1'b0;
      end else if (ctrlWr && wrData[0]) begin
         runSeen_r <= 1'b1;
      end else if (ctrlWr && wrData[1]) begin
         runSeen_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         maskNz_r <= 1'b0;
      end else if (wrEn && addr == 8'h24) begin
         maskNz_r <= |wrData[3:0];
      end
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_rd_idle_zero: assert property ((rdData != 32'h0) |-> $past(rdEn))
      else $error("read data outside its slot");
   a_rd_unmapped: assert property ((rdEn && addr == 8'h30) |=> rdData == 32'h0)
      else $error("unmapped read not zero");
   a_start_clears: assert property ((ctrlWr && wrData[0]) |=> !trigOut)
      else $error("trigger output kept over start");
   a_halt_drop: assert property ((ctrlWr && wrData[1] && !wrData[0]) |-> ##[1:2] !trigOut)
      else $error("halt left trigger output high");
   a_trig_cause: assert property ($fell(trigOut) |-> $past(ctrlCmd) || $past(ctrlCmd, 2))
      else $error("trigger output fell uncommanded");
   a_trig_run: assert property ($rose(trigOut) |-> $past(runSeen_r))
      else $error("trigger output rose outside a run");
   a_start_running: assert property ((ctrlWr && wrData[1:0] == 2'b01 ##2 rdEn && addr == 8'h04)
      |=> rdData[1:0] == 2'h1)
      else $error("run status not running after start");
   a_irq_masked: assert property (irq |-> maskNz_r || $past(maskNz_r) || $past(maskNz_r, 2))
      else $error("interrupt with empty mask");
endmodule

bind btc_capture btc_capture_props #(.MEM_DEPTH(MEM_DEPTH)) btc_capture_props_i (
   .mclk(mclk),
   .rst_n(rst_n),
   .addr(addr),
   .wrData(wrData),
   .wrEn(wrEn),
   .rdEn(rdEn),
   .rdData(rdData),
   .probeBus(probeBus),
   .armIn(armIn),
   .trigOut(trigOut),
   .irq(irq)
);
`default_nettype wire

//--- dv/btc_capture_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module btc_capture_tb_top;
   // Short depth keeps each trace to 16 cycles
   localparam int DEPTH = 16;
   logic mclk;
   logic rst_n;
   logic [7:0] addr;
   logic [31:0] wrData;
   logic wrEn;
   logic rdEn;
   logic [31:0] rdData;
   logic [31:0] probeBus;
   logic armIn;
   logic armReq;
   logic trigOut;
   logic irq;
   int num_errors;
   int n_tests;

   btc_capture #(.MEM_DEPTH(DEPTH), .ARM_MAX_CYC(50), .ARM_LG_CYC(100)) btc_capture_i (
      .mclk(mclk),
      .rst_n(rst_n),
      .addr(addr),
      .wrData(wrData),
      .wrEn(wrEn),
      .rdEn(rdEn),
      .rdData(rdData),
      .probeBus(probeBus),
      .armIn(armIn),
      .trigOut(trigOut),
      .irq(irq)
   );

   btc_bus_model btc_bus_model_i (
      .mclk(mclk),
      .rst_n(rst_n),
      .armReq(armReq),
      .probeBus(probeBus),
      .armIn(armIn)
   );

   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge mclk);
      wrEn <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge mclk);
      rdEn <= 1'b0;
      #1;
      d = rdData;
   endtask

   task automatic wait_run(input logic [1:0] run);
      logic [31:0] d;
      for (int i = 0; i < 200; i++) begin
         rd(8'h04, d);
         if (d[1:0] === run) break;
      end
      check({30'h0, d[1:0]}, {30'h0, run});
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_reset();
      logic [31:0] d;
      rd(8'h04, d);
      check(d, 32'h0);
      rd(8'h08, d);
      check(d, {16'(DEPTH), 16'h0});
      rd(8'h44, d);
      check(d, 32'h0);
      wr(8'h00, 32'h8);
      rd(8'h00, d);
      check(d, 32'h8);
      rd(8'h08, d);
      check(d, {16'(DEPTH), 16'h0});
      wr(8'h30, 32'hFFFF_FFFF);
      rd(8'h30, d);
      check(d, 32'h0);
      $display("test_reset done");
   endtask

   task automatic test_full();
      logic [31:0] d;
      logic [31:0] first;
      wr(8'h24, 32'h2);
      wr(8'h00, 32'h1);
      wait_run(2'h2);
      rd(8'h04, d);
      check(d, 32'h0000_0112);
      rd(8'h08, d);
      check(d, {16'(DEPTH), 16'(DEPTH)});
      rd(8'h0C, d);
      check(d, {16'(DEPTH - 1), 16'h0});
      rd(8'h20, d);
      check(d, 32'h3);
      check({31'h0, irq}, 32'h1);
      wr(8'h24, 32'h0);
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h0);
      wr(8'h24, 32'h2);
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h1);
      wr(8'h20, 32'hF);
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h0);
      wr(8'h28, 32'h0);
      rd(8'h2C, first);
      for (int i = 1; i < DEPTH; i++) begin
         rd(8'h2C, d);
         check(d, first + 32'(i));
      end
      $display("test_full done");
   endtask

   task automatic test_halt_idle();
      logic [31:0] d;
      wr(8'h48, 32'h3);
      wr(8'h50, 32'hFFFF_0000);
      wr(8'h54, 32'hFFFF_FFFF);
      wr(8'h58, 32'h5);
      wr(8'h00, 32'h11);
      repeat (10) @(posedge mclk);
      rd(8'h04, d);
      check(d, 32'h0000_0101);
      rd(8'h10, d);
      check(d, 32'h5);
      rd(8'h1C, d);
      check(d, 32'h1);
      wr(8'h00, 32'h12);
      rd(8'h04, d);
      check(d, 32'h0000_0103);
      rd(8'h08, d);
      check(d, {16'(DEPTH), 16'h0});
      $display("test_halt_idle done");
   endtask

   task automatic test_halt_store();
      logic [31:0] d;
      logic [31:0] d2;
      wr(8'h48, 32'h1);
      wr(8'h00, 32'h1);
      for (int i = 0; i < 20 && trigOut !== 1'b1; i++) @(posedge mclk);
      check({31'h0, trigOut}, 32'h1);
      wr(8'h00, 32'h2);
      repeat (2) @(posedge mclk);
      check({31'h0, trigOut}, 32'h0);
      rd(8'h04, d);
      check(d, 32'h0000_0113);
      rd(8'h08, d);
      rd(8'h08, d2);
      check(d2, d);
      check({31'h0, d[15:0] != 16'h0 && d[15:0] < 16'(DEPTH)}, 32'h1);
      $display("test_halt_store done");
   endtask

   task automatic test_arm();
      logic [31:0] d;
      wr(8'h00, 32'h5);
      rd(8'h04, d);
      check({28'h0, d[3:0]}, 32'h5);
      wait_run(2'h2);
      @(posedge mclk);
      armReq <= 1'b1;
      repeat (6) @(posedge mclk);
      armReq <= 1'b0;
      rd(8'h04, d);
      check({28'h0, d[3:0]}, 32'hA);
      rd(8'h1C, d);
      check(d, 32'h2);
      // Late arm saturates one cycle below the -5 cycle floor
      rd(8'h14, d);
      check(d, 32'hFFFF_FFFA);
      rd(8'h18, d);
      check(d, 32'h0000_00FF);
      rd(8'h20, d);
      check({31'h0, d[3]}, 32'h1);
      wr(8'h00, 32'h5);
      rd(8'h04, d);
      check({30'h0, d[3:2]}, 32'h1);
      wait_run(2'h2);
      $display("test_arm done");
   endtask

   task automatic test_arm_early();
      logic [31:0] d;
      wr(8'h48, 32'hC8);
      wr(8'h00, 32'h5);
      @(posedge mclk);
      armReq <= 1'b1;
      repeat (4) @(posedge mclk);
      armReq <= 1'b0;
      wait_run(2'h2);
      rd(8'h04, d);
      check({28'h0, d[3:0]}, 32'hA);
      rd(8'h1C, d);
      check(d, 32'h4);
      // Arm 200 states ahead of the trigger runs past the 50-cycle limit
      rd(8'h14, d);
      check(d, 32'h0000_0033);
      rd(8'h18, d);
      check(d, 32'h0);
      $display("test_arm_early done");
   endtask

   // ==========================================================
   // Clock, reset, sequence and watchdog
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial begin
      rst_n = 1'b0;
      addr = 8'h0;
      wrData = 32'h0;
      wrEn = 1'b0;
      rdEn = 1'b0;
      armReq = 1'b0;
      num_errors = 0;
      n_tests = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      test_reset();
      test_full();
      test_halt_idle();
      test_halt_store();
      test_arm();
      test_arm_early();
      report_and_stop();
   end

   // A full run needs a few hundred cycles; far beyond that means a hang
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
